// [tspe_mac_end.sv]
/*
  tspe_mac_end: MAC-side packet-end handling of the segmented user bus.
  Assumes the user end honours ready; a downstream MAC drains the FIFO.
*/
// How it works
// - user raises end flag on final transfer
// - end flag counts only when segment valid
// - user raises error flag only for errored packets
// - error flag sampled only with valid and end
// - errored packet's last word becomes error code
// - frame check off for errored packet only
// - user gives empty byte count on last transfer
// - empty count sampled only with valid and end
// - errored end forces empty low bits zero
// - empty count top bit kept as given
// - four segments each with own flags
// - segment signals sampled only when valid; start flag never sampled
// - payload captured whenever segment valid, except on errored end
// - user raises start flag on first transfer
`timescale 1ns/100ps
module tspe_mac_end import tspe_pkg::*; #(
  parameter int DEPTH = TSPE_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // bus
  tspe_bus_if.mac bus,
  // output stream toward the MAC
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [1:0] out_segment_out,
  output logic [TSPE_DATA_W-1:0] out_word_out,
  output logic out_start_out,
  output logic out_end_out,
  output logic out_errored_out,
  output logic [TSPE_COUNT_W-1:0] out_bytes_out,
  output logic out_fcs_check_out
);
  localparam int FW = TSPE_SEGMENTS * TSPE_SEG_W;
  function automatic logic [TSPE_EMPTY_W-1:0] eff_empty(
    input logic err, input logic [TSPE_EMPTY_W-1:0] raw);
    eff_empty = err ? (raw & TSPE_EMPTY_LOW_MASK) : raw;
  endfunction : eff_empty
  // one present segment: error and empty only count at its end
  function automatic logic [TSPE_SEG_W-1:0] pack_seg(input logic e, input logic err,
    input logic [TSPE_EMPTY_W-1:0] raw, input logic [TSPE_DATA_W-1:0] data);
    logic r;
    r = e && err;
    pack_seg = {1'b1, e, r, e ? eff_empty(r, raw) : TSPE_EMPTY_W'(0),
      r ? TSPE_ERROR_WORD : data};
  endfunction : pack_seg
  // segment fields gated by valid
  logic [FW-1:0] pack;
  always_comb begin
    pack = '0;
    for (int s = 0; s < TSPE_SEGMENTS; s++) begin
      if (bus.segment_valid[s]) begin
        pack[s*TSPE_SEG_W +: TSPE_SEG_W] = pack_seg(bus.segment_end_flag[s],
          bus.segment_error_flag[s], bus.segment_empty_count[s], bus.segment_payload[s]);
      end
    end
  end
  wire any_valid = |bus.segment_valid;
  logic [FW-1:0] head;
  logic head_valid;
  logic head_pop;
  logic fifo_room;
  tspe_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .in_valid_in(any_valid),
    .in_ready_out(fifo_room),
    .in_data_in(pack),
    .out_valid_out(head_valid),
    .out_ready_in(head_pop),
    .out_data_out(head)
  );
  // serialise segments of one FIFO word, lowest first
  logic [1:0] seg;
  wire [TSPE_SEG_W-1:0] cur = head[seg*TSPE_SEG_W +: TSPE_SEG_W];
  wire cur_present = cur[TSPE_SEG_W-1];
  wire cur_end = cur[TSPE_SEG_W-2];
  wire cur_err = cur[TSPE_SEG_W-3];
  wire [TSPE_EMPTY_W-1:0] cur_empty = cur[TSPE_DATA_W +: TSPE_EMPTY_W];
  wire last_seg = (seg == 2'(TSPE_SEGMENTS-1));
  wire emit = head_valid && cur_present && (!out_valid_out || out_ready_in);
  wire step = head_valid && (!cur_present || !out_valid_out || out_ready_in);
  assign head_pop = step && last_seg;
  // occupancy mirror: a word accepted now lands one cycle later
  localparam int LW = $clog2(DEPTH) + 1;
  logic [LW-1:0] level;
  wire push_seen = any_valid && fifo_room;
  wire [LW:0] level_ahead = {1'b0, level} + (LW+1)'(any_valid);
  assign bus.ready = (level_ahead < (LW+1)'(DEPTH));
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) level <= '0;
    else level <= level + LW'(push_seen) - LW'(head_pop);
  end
  logic in_packet;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      seg <= '0;
      out_valid_out <= 1'b0;
      out_segment_out <= '0;
      out_word_out <= '0;
      out_start_out <= 1'b0;
      out_end_out <= 1'b0;
      out_errored_out <= 1'b0;
      out_bytes_out <= '0;
      out_fcs_check_out <= 1'b1;
      in_packet <= 1'b0;
    end else begin
      if (out_ready_in) out_valid_out <= 1'b0;
      if (step) seg <= seg + 2'h1;
      if (emit) begin
        out_valid_out <= 1'b1;
        out_segment_out <= seg;
        out_word_out <= cur[TSPE_DATA_W-1:0];
        out_start_out <= !in_packet;
        out_end_out <= cur_end;
        out_errored_out <= cur_err;
        out_bytes_out <= cur_end ? TSPE_FULL_BYTES - TSPE_COUNT_W'(cur_empty)
                                 : TSPE_FULL_BYTES;
        out_fcs_check_out <= !cur_err;
        in_packet <= !cur_end;
      end
    end
  end
endmodule : tspe_mac_end

// [tspe_pkg.sv]
/*
  tspe_pkg: shared constants for the segmented transmit bus packet-end logic.
  Assumes a single transmit clock shared by both ends.
*/
package tspe_pkg;
  localparam int TSPE_SEGMENTS = 4;
  localparam int TSPE_DATA_W = 128;
  localparam int TSPE_EMPTY_W = 4;
  localparam int TSPE_BYTES = 16;
  localparam int TSPE_FIFO_DEPTH = 16;
  localparam int TSPE_COUNT_W = 5;
  localparam int TSPE_EMPTY_LOW_W = 3;
  localparam logic [TSPE_EMPTY_W-1:0] TSPE_EMPTY_LOW_MASK = 4'h8;
  localparam logic [TSPE_COUNT_W-1:0] TSPE_FULL_BYTES = 5'h10;
  // error control block: all sixteen byte lanes carry the error character
  localparam logic [TSPE_DATA_W-1:0] TSPE_ERROR_WORD = {16{8'hFE}};
  // one segment's worth of per-segment signals
  localparam int TSPE_SEG_W = TSPE_DATA_W + 3 + TSPE_EMPTY_W;
endpackage : tspe_pkg

// [tspe_bus_if.sv]
/*
  tspe_bus_if: the segmented user bus between user transmit logic and the MAC end.
  Assumes both modports share clk_sys_in.
*/
`timescale 1ns/100ps
interface tspe_bus_if;
  import tspe_pkg::*;
  logic [TSPE_SEGMENTS-1:0] segment_valid;
  logic [TSPE_SEGMENTS-1:0] segment_start_flag;
  logic [TSPE_SEGMENTS-1:0] segment_end_flag;
  logic [TSPE_SEGMENTS-1:0] segment_error_flag;
  logic [TSPE_SEGMENTS-1:0][TSPE_EMPTY_W-1:0] segment_empty_count;
  logic [TSPE_SEGMENTS-1:0][TSPE_DATA_W-1:0] segment_payload;
  logic ready;
  modport user (output segment_valid, segment_start_flag, segment_end_flag,
    segment_error_flag, segment_empty_count, segment_payload, input ready);
  modport mac (input segment_valid, segment_start_flag, segment_end_flag,
    segment_error_flag, segment_empty_count, segment_payload, output ready);
endinterface : tspe_bus_if

// [tspe_fifo.sv]
/*
  tspe_fifo: synchronous valid/ready FIFO, parameter width and depth.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module tspe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  always_ff @(posedge clk_sys_in) begin
    if (push) mem[wr_ptr] <= in_data_in;
  end
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tspe_fifo

// [tspe_user_end.sv]
/*
  tspe_user_end: user transmit logic driving the segmented user bus.
  Assumes the caller offers one segment at a time with its packet markers.
*/
`timescale 1ns/100ps
module tspe_user_end import tspe_pkg::*; (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // user request
  input wire logic send_valid_in,
  output logic send_ready_out,
  input wire logic [1:0] send_segment_in,
  input wire logic send_first_in,
  input wire logic send_last_in,
  input wire logic send_bad_in,
  input wire logic [TSPE_EMPTY_W-1:0] send_empty_in,
  input wire logic [TSPE_DATA_W-1:0] send_payload_in,
  // bus
  tspe_bus_if.user bus
);
  logic [TSPE_SEGMENTS-1:0] valid;
  logic [TSPE_SEGMENTS-1:0] start;
  logic [TSPE_SEGMENTS-1:0] last;
  logic [TSPE_SEGMENTS-1:0] bad;
  logic [TSPE_SEGMENTS-1:0][TSPE_EMPTY_W-1:0] empty;
  logic [TSPE_SEGMENTS-1:0][TSPE_DATA_W-1:0] payload;
  wire take = send_valid_in && send_ready_out;
  assign send_ready_out = bus.ready;
  assign bus.segment_valid = valid;
  assign bus.segment_start_flag = start;
  assign bus.segment_end_flag = last;
  assign bus.segment_error_flag = bad;
  assign bus.segment_empty_count = empty;
  assign bus.segment_payload = payload;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      valid <= '0;
      start <= '0;
      last <= '0;
      bad <= '0;
      empty <= '0;
      payload <= '0;
    end else begin
      valid <= '0;
      start <= '0;
      last <= '0;
      bad <= '0;
      empty <= '0;
      payload <= '0;
      if (take) begin
        valid[send_segment_in] <= 1'b1;
        start[send_segment_in] <= send_first_in;
        last[send_segment_in] <= send_last_in;
        bad[send_segment_in] <= send_last_in && send_bad_in;
        empty[send_segment_in] <= send_last_in ? send_empty_in : '0;
        payload[send_segment_in] <= send_payload_in;
      end
    end
  end
endmodule : tspe_user_end

// [tspe_bus_sva.sv]
/*
  tspe_bus_sva: checks on the segmented user bus between the two ends.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module tspe_bus_sva import tspe_pkg::*; (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // bus
  input wire logic [TSPE_SEGMENTS-1:0] segment_valid,
  input wire logic [TSPE_SEGMENTS-1:0] segment_start_flag,
  input wire logic [TSPE_SEGMENTS-1:0] segment_end_flag,
  input wire logic [TSPE_SEGMENTS-1:0] segment_error_flag,
  input wire logic [TSPE_SEGMENTS-1:0][TSPE_EMPTY_W-1:0] segment_empty_count,
  input wire logic [TSPE_SEGMENTS-1:0][TSPE_DATA_W-1:0] segment_payload,
  input wire logic ready
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // idle segments carrying leftovers
  logic [TSPE_SEGMENTS-1:0] stray_empty;
  logic [TSPE_SEGMENTS-1:0] stray_payload;
  always_comb begin
    for (int i = 0; i < TSPE_SEGMENTS; i++) begin
      stray_empty[i] = !segment_valid[i] && segment_empty_count[i] != '0;
      stray_payload[i] = !segment_valid[i] && segment_payload[i] != '0;
    end
  end
  property p_end_valid; (segment_end_flag & ~segment_valid) == '0; endproperty
  a_end_valid: assert property (p_end_valid) else $error("end without valid");
  property p_err_end; (segment_error_flag & ~segment_end_flag) == '0; endproperty
  a_err_end: assert property (p_err_end) else $error("error without end");
  property p_empty_idle; stray_empty == '0; endproperty
  a_empty_idle: assert property (p_empty_idle) else $error("empty on idle");
  property p_start_valid; (segment_start_flag & ~segment_valid) == '0; endproperty
  a_start_valid: assert property (p_start_valid) else $error("start without valid");
  property p_payload_idle; stray_payload == '0; endproperty
  a_payload_idle: assert property (p_payload_idle) else $error("payload on idle");
  property p_one_segment; $onehot0(segment_valid); endproperty
  a_one_segment: assert property (p_one_segment) else $error("two segments");
  property p_reset_idle; disable iff (1'b0) reset_in |=> segment_valid == '0; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("valid after reset");
  property p_ready_release; $fell(reset_in) |-> ready; endproperty
  a_ready_release: assert property (p_ready_release) else $error("not ready");
  c_error_end: cover property ((segment_error_flag & segment_valid) != '0);
  c_refused: cover property (!ready);
  c_back_to_back: cover property (segment_valid != '0 ##1 segment_valid != '0);
endmodule : tspe_bus_sva

// [tx_segment_packet_end_test.sv]
/*
  tx_segment_packet_end_test: both ends joined by the bus, driven from the user side.
  Assumes a 50 MHz clock and the constants of tspe_pkg.
*/
`timescale 1ns/100ps
module tx_segment_packet_end_test import tspe_pkg::*; ;
  logic clk_sys_in, reset_in, send_valid, first, last, bad, out_ready, send_ready;
  logic o_valid, o_start, o_end, o_err, o_fcs;
  logic [1:0] seg, o_seg;
  logic [3:0] empty;
  logic [127:0] payload, o_word;
  logic [4:0] o_bytes;
  int mismatches = 0;
  int n_tests = 0;
  tspe_bus_if bus ();
  tspe_user_end tspe_user_end_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .send_valid_in(send_valid), .send_ready_out(send_ready), .send_segment_in(seg),
    .send_first_in(first), .send_last_in(last), .send_bad_in(bad), .send_empty_in(empty),
    .send_payload_in(payload), .bus(bus.user));
  tspe_mac_end tspe_mac_end_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .bus(bus.mac), .out_valid_out(o_valid), .out_ready_in(out_ready), .out_segment_out(o_seg),
    .out_word_out(o_word), .out_start_out(o_start), .out_end_out(o_end),
    .out_errored_out(o_err), .out_bytes_out(o_bytes), .out_fcs_check_out(o_fcs));
  tspe_bus_sva tspe_bus_sva_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .segment_valid(bus.segment_valid), .segment_start_flag(bus.segment_start_flag),
    .segment_end_flag(bus.segment_end_flag), .segment_error_flag(bus.segment_error_flag),
    .segment_empty_count(bus.segment_empty_count), .segment_payload(bus.segment_payload),
    .ready(bus.ready));
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic send(input logic [1:0] s, input logic f, l, b, input logic [3:0] e);
    logic r;
    @(posedge clk_sys_in);
    {send_valid, seg, first, last, bad, empty, payload} <= {1'b1, s, f, l, b, e, {8{16'hC3A5}}};
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys_in);
      r = send_ready;
      @(posedge clk_sys_in);
      if (r) break;
      if (i == 39) begin
        check("send wait", 1'b1, 1'b0);
        tally_and_finish();
      end
    end
    send_valid <= 1'b0;
  endtask : send
  task automatic take(input logic [1:0] s, input logic [127:0] w, input logic e, er, fc,
      input logic [4:0] by, input logic st);
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_sys_in);
      if (o_valid === 1'b1) break;
    end
    if (i == 20) check("out wait", 1'b1, 1'b0);
    if (i == 20) tally_and_finish();
    check("segment", o_seg, s);
    check("word", o_word, w);
    check("end", o_end, e);
    check("errored", o_err, er);
    check("fcs", o_fcs, fc);
    check("bytes", o_bytes, by);
    check("start", o_start, st);
  endtask : take
  task automatic sc_segments;
    for (int s = 0; s < TSPE_SEGMENTS; s++) begin
      send(2'(s), 1'b1, 1'b0, 1'b0, 4'hF);
      take(2'(s), {8{16'hC3A5}}, 1'b0, 1'b0, 1'b1, TSPE_FULL_BYTES, s == 0);
    end
  endtask : sc_segments
  task automatic sc_good_end;
    send(2'h2, 1'b0, 1'b1, 1'b0, 4'h5);
    take(2'h2, {8{16'hC3A5}}, 1'b1, 1'b0, 1'b1, 5'h0B, 1'b0);
  endtask : sc_good_end
  task automatic sc_bad_end;
    logic [3:0] e [2] = '{4'hD, 4'h7};
    logic [4:0] by [2] = '{5'h08, 5'h10};
    for (int k = 0; k < 2; k++) begin
      send(2'h1, 1'b0, 1'b1, 1'b1, e[k]);
      take(2'h1, TSPE_ERROR_WORD, 1'b1, 1'b1, 1'b0, by[k], 1'b1);
    end
  endtask : sc_bad_end
  task automatic sc_restore;
    send(2'h3, 1'b1, 1'b0, 1'b1, 4'h3);
    take(2'h3, {8{16'hC3A5}}, 1'b0, 1'b0, 1'b1, TSPE_FULL_BYTES, 1'b1);
  endtask : sc_restore
  task automatic sc_fill;
    int n = 0;
    int k = 0;
    @(posedge clk_sys_in);
    out_ready <= 1'b0;
    {send_valid, seg, first, last, bad, empty, payload} <=
      {1'b1, 2'h0, 1'b1, 1'b1, 1'b0, 4'h0, 128'h1};
    repeat (40) begin
      @(negedge clk_sys_in);
      if (send_ready === 1'b1) n++;
      @(posedge clk_sys_in);
    end
    send_valid <= 1'b0;
    @(negedge clk_sys_in);
    check("refused", send_ready, 1'b0);
    check("accepted", n >= TSPE_FIFO_DEPTH, 1'b1);
    @(posedge clk_sys_in);
    out_ready <= 1'b1;
    repeat (100) begin
      @(negedge clk_sys_in);
      if (o_valid === 1'b1) k++;
    end
    check("drained", k, n);
  endtask : sc_fill
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {send_valid, seg, first, last, bad, empty, payload} = '0;
    out_ready = 1'b1;
    reset_in = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    sc_segments();
    sc_good_end();
    sc_bad_end();
    sc_restore();
    sc_fill();
    tally_and_finish();
  end
endmodule : tx_segment_packet_end_test
